// >>> rtl/move_and_option_instr_decode.sv
// Purpose: decode and execute copy, literal load, store, idle and option load
// Assumes: program words arrive on the same clock with a valid/ready handshake
// Notes:   one instruction cycle is two clocks: operand read, then execute
`timescale 1ns/1ns
`default_nettype none
`include "move_consts.svh"

module move_and_option_instr_decode (
   input  wire logic                  REF_CLK,
   input  wire logic                  RST,
   input  wire logic [`WORD_W-1:0]    INSTR_WORD,
   input  wire logic                  INSTR_VALID,
   output logic                       INSTR_READY,
   output logic                       INSTR_DONE,
   output logic                       INSTR_UNSUPPORTED,
   output logic      [`DATA_W-1:0]    ACC_OUT,
   output logic      [`DATA_W-1:0]    OPTION_OUT,
   output logic                       ZERO_FLAG,
   output logic                       FILE_WR_EN,
   output logic      [`FADDR_W-1:0]   FILE_WR_ADDR,
   output logic      [`DATA_W-1:0]    FILE_WR_DATA
);

   function automatic move_pkg::op_t decode_word(input logic [`WORD_W-1:0] w);
      move_pkg::op_t op;
      op = move_pkg::OP_OTHER;
      if (w == `IDLE_WORD) begin
         op = move_pkg::OP_IDLE;
      end else if (w == `OPTION_WORD) begin
         op = move_pkg::OP_OPTION;
      end else if (w[`COPY_PREFIX_MSB:`COPY_PREFIX_LSB] == `COPY_PREFIX) begin
         op = move_pkg::OP_COPY;
      end else if (w[`LIT_PREFIX_MSB:`LIT_PREFIX_LSB] == `LIT_PREFIX) begin
         op = move_pkg::OP_LITERAL;
      end else if (w[`STORE_PREFIX_MSB:`STORE_PREFIX_LSB] == `STORE_PREFIX) begin
         op = move_pkg::OP_STORE;
      end
      return op;
   endfunction

   logic [`WORD_W-1:0]    instr_reg;
   logic [`WORD_W-1:0]    instr_next;
   logic                  busy_reg;
   logic                  busy_next;
   logic                  ready_reg;
   logic                  done_reg;
   logic                  unsup_reg;
   logic [`DATA_W-1:0]    acc_reg;
   logic [`DATA_W-1:0]    acc_next;
   logic [`DATA_W-1:0]    option_reg;
   logic [`DATA_W-1:0]    option_next;
   logic                  zero_reg;
   logic                  zero_next;
   logic                  fwr_en_reg;
   logic [`FADDR_W-1:0]   fwr_addr_reg;
   logic [`DATA_W-1:0]    fwr_data_reg;

   wire logic                  take;
   wire move_pkg::op_t         op;
   wire logic                  exec;
   wire logic                  dest_file;
   wire logic [`FADDR_W-1:0]   faddr;
   wire logic [`DATA_W-1:0]    literal;
   wire logic [`DATA_W-1:0]    file_rd_data;
   wire logic                  exec_copy;
   wire logic                  exec_lit;
   wire logic                  exec_store;
   wire logic                  exec_opt;
   wire logic                  exec_idle;
   wire logic                  exec_other;
   wire logic                  mem_we;
   wire logic [`DATA_W-1:0]    mem_wdata;

   assign take       = INSTR_VALID && ready_reg;
   assign exec       = busy_reg;
   assign op         = decode_word(instr_reg);
   assign dest_file  = instr_reg[`DEST_BIT];
   assign faddr      = instr_reg[`FADDR_MSB:`FADDR_LSB];
   assign literal    = instr_reg[`LIT_MSB:`LIT_LSB];
   assign exec_copy  = exec && (op == move_pkg::OP_COPY);
   assign exec_lit   = exec && (op == move_pkg::OP_LITERAL);
   assign exec_store = exec && (op == move_pkg::OP_STORE);
   assign exec_opt   = exec && (op == move_pkg::OP_OPTION);
   assign exec_idle  = exec && (op == move_pkg::OP_IDLE);
   assign exec_other = exec && (op == move_pkg::OP_OTHER);

   // copy with dest 1 writes the value back to the same register
   // store writes the accumulator to the addressed register
   assign mem_we    = (exec_copy && dest_file) || exec_store;
   assign mem_wdata = exec_store ? acc_reg : file_rd_data;

   assign instr_next = take ? INSTR_WORD : instr_reg;
   // one instruction cycle, read then execute
   assign busy_next  = take;

   // copy with dest 0 loads the accumulator
   assign acc_next = (exec_copy && !dest_file) ? file_rd_data :
                     exec_lit                  ? literal      :
                                                 acc_reg;

   assign option_next = exec_opt ? acc_reg : option_reg;

   // zero flag follows the moved value on copy only
   assign zero_next = exec_copy ? (file_rd_data == {`DATA_W{1'b0}}) : zero_reg;

   // operand address comes straight from the incoming word
   file_reg_mem u_file_reg_mem (
      .clk     (REF_CLK),
      .wr_en   (mem_we),
      .wr_addr (faddr),
      .wr_data (mem_wdata),
      .rd_addr (INSTR_WORD[`FADDR_MSB:`FADDR_LSB]),
      .rd_data (file_rd_data)
   );

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         instr_reg <= `IDLE_WORD;
         busy_reg  <= 1'b0;
         ready_reg <= 1'b0;
         done_reg  <= 1'b0;
         unsup_reg <= 1'b0;
      end else begin
         instr_reg <= instr_next;
         busy_reg  <= busy_next;
         ready_reg <= !take;
         done_reg  <= exec;
         unsup_reg <= exec_other;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         acc_reg    <= `ACC_RESET;
         option_reg <= `OPTION_RESET;
         zero_reg   <= `ZERO_RESET;
      end else begin
         acc_reg    <= acc_next;
         option_reg <= option_next;
         zero_reg   <= zero_next;
      end
   end

   // mirror of the file write, visible one clock after the execute step
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         fwr_en_reg   <= 1'b0;
         fwr_addr_reg <= {`FADDR_W{1'b0}};
         fwr_data_reg <= {`DATA_W{1'b0}};
      end else begin
         fwr_en_reg <= mem_we;
         if (mem_we) begin
            fwr_addr_reg <= faddr;
            fwr_data_reg <= mem_wdata;
         end
      end
   end

   assign INSTR_READY       = ready_reg;
   assign INSTR_DONE        = done_reg;
   assign INSTR_UNSUPPORTED = unsup_reg;
   assign ACC_OUT           = acc_reg;
   assign OPTION_OUT        = option_reg;
   assign ZERO_FLAG         = zero_reg;
   assign FILE_WR_EN        = fwr_en_reg;
   assign FILE_WR_ADDR      = fwr_addr_reg;
   assign FILE_WR_DATA      = fwr_data_reg;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   sequence s_take_copy;
      take && (decode_word(INSTR_WORD) == move_pkg::OP_COPY);
   endsequence

   sequence s_exec_then_done;
      busy_reg && !ready_reg ##1 INSTR_DONE && INSTR_READY;
   endsequence

   sequence s_take_any;
      INSTR_VALID && INSTR_READY;
   endsequence

   a_copy_decode: assert property (
      s_take_copy |=> exec_copy && (instr_reg == $past(INSTR_WORD)))
      else $error("copy word not decoded as copy");

   a_copy_to_acc: assert property (
      (exec_copy && !dest_file) |=> (ACC_OUT == $past(file_rd_data)) && !FILE_WR_EN)
      else $error("copy to accumulator wrong");

   a_copy_to_file: assert property (
      (exec_copy && dest_file) |=> $stable(ACC_OUT) && FILE_WR_EN
         && (FILE_WR_DATA == $past(file_rd_data)) && (FILE_WR_ADDR == $past(faddr)))
      else $error("copy back to file register wrong");

   a_copy_zero_flag: assert property (
      exec_copy |=> ZERO_FLAG == ($past(file_rd_data) == {`DATA_W{1'b0}}))
      else $error("zero flag not updated by copy");

   a_literal_load: assert property (
      exec_lit |=> (ACC_OUT == $past(literal)) && $stable(ZERO_FLAG) && !FILE_WR_EN)
      else $error("literal load wrong");

   a_store_acc: assert property (
      exec_store |=> FILE_WR_EN && (FILE_WR_DATA == $past(acc_reg))
         && (FILE_WR_ADDR == $past(faddr)) && $stable(ZERO_FLAG) && $stable(ACC_OUT))
      else $error("store accumulator wrong");

   a_option_load: assert property (
      exec_opt |=> (OPTION_OUT == $past(acc_reg)) && $stable(ZERO_FLAG) && $stable(ACC_OUT))
      else $error("option load wrong");

   a_idle_nochange: assert property (
      exec_idle |=> $stable(ACC_OUT) && $stable(OPTION_OUT) && $stable(ZERO_FLAG)
         && !FILE_WR_EN)
      else $error("idle changed state");

   a_single_cycle: assert property (
      s_take_any |=> s_exec_then_done)
      else $error("instruction did not finish in one cycle");

endmodule

`default_nettype wire

// >>> rtl/move_consts.svh
// Purpose: constants for the move and option instruction decoder
// Assumes: 12-bit program words, 8-bit data, 32 file registers
// Notes:   opcode fields are matched on the upper bits of the word
`ifndef MOVE_CONSTS_SVH
`define MOVE_CONSTS_SVH

`define WORD_W            12
`define DATA_W            8
`define FADDR_W           5
`define FILE_DEPTH        32

// opcode prefixes and fixed words
`define COPY_PREFIX       6'h08
`define COPY_PREFIX_MSB   11
`define COPY_PREFIX_LSB   6
`define LIT_PREFIX        4'hC
`define LIT_PREFIX_MSB    11
`define LIT_PREFIX_LSB    8
`define STORE_PREFIX      7'h01
`define STORE_PREFIX_MSB  11
`define STORE_PREFIX_LSB  5
`define OPTION_WORD       12'h002
`define IDLE_WORD         12'h000

// operand field positions
`define DEST_BIT          5
`define FADDR_MSB         4
`define FADDR_LSB         0
`define LIT_MSB           7
`define LIT_LSB           0

// reset values
`define ACC_RESET         8'h00
`define OPTION_RESET      8'hFF
`define ZERO_RESET        1'b0

`endif

// >>> rtl/move_pkg.sv
// Purpose: types shared by the move and option instruction decoder
// Assumes: nothing beyond the constants header
// Notes:   op_other covers every word this block does not execute
`default_nettype none
package move_pkg;

   typedef enum logic [2:0] {
      OP_IDLE,
      OP_COPY,
      OP_LITERAL,
      OP_STORE,
      OP_OPTION,
      OP_OTHER
   } op_t;

endpackage

`default_nettype wire

// >>> rtl/file_reg_mem.sv
// Purpose: 32 x 8 file register storage
// Assumes: one write port, one read port, same clock
// Notes:   read data come from a register one edge after the address
`timescale 1ns/1ns
`default_nettype none
`include "move_consts.svh"

module file_reg_mem (
   input  wire logic                  clk,
   input  wire logic                  wr_en,
   input  wire logic [`FADDR_W-1:0]   wr_addr,
   input  wire logic [`DATA_W-1:0]    wr_data,
   input  wire logic [`FADDR_W-1:0]   rd_addr,
   output logic      [`DATA_W-1:0]    rd_data
);

   logic [`DATA_W-1:0] mem [0:`FILE_DEPTH-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read-before-write on a shared address
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// >>> sim/move_and_option_instr_decode_tb.sv
// Purpose: self-checking bench for the move and option instruction decoder
// Assumes: DONE in the second cycle after the take edge, READY back high then
// Notes:   file contents survive reset, so the model keeps its copy
`timescale 1ns/1ns
`default_nettype none
`include "move_consts.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module move_and_option_instr_decode_tb;
   logic                 ref_clk;
   logic                 rst;
   logic [`WORD_W-1:0]   instr_word;
   logic                 instr_valid;
   logic                 ready;
   logic                 done;
   logic                 unsup;
   logic [`DATA_W-1:0]   acc;
   logic [`DATA_W-1:0]   opt;
   logic                 zero;
   logic                 wr_en;
   logic [`FADDR_W-1:0]  wr_addr;
   logic [`DATA_W-1:0]   wr_data;
   int                   errors;
   int                   comparisons;
   logic [31:0]          seed;
   logic [7:0]           m_acc;
   logic [7:0]           m_opt;
   logic                 m_z;
   logic [7:0]           mem [32];
   // zero test by copy back to itself (12'h223), copy back of non-zero fill data (12'h225)
   logic [11:0]          w_list [12] = '{12'hC00, 12'h023, 12'h203, 12'h223, 12'hC5A,
      12'h024, 12'h204, 12'h000, 12'h002, 12'h225, 12'h205, 12'hFFF};

   move_and_option_instr_decode dut (
      .REF_CLK(ref_clk), .RST(rst), .INSTR_WORD(instr_word), .INSTR_VALID(instr_valid),
      .INSTR_READY(ready), .INSTR_DONE(done), .INSTR_UNSUPPORTED(unsup), .ACC_OUT(acc),
      .OPTION_OUT(opt), .ZERO_FLAG(zero), .FILE_WR_EN(wr_en), .FILE_WR_ADDR(wr_addr),
      .FILE_WR_DATA(wr_data));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic do_reset(input int n);
      rst = 1'b1;
      repeat (n) @(negedge ref_clk);
      m_acc = `ACC_RESET;
      m_opt = `OPTION_RESET;
      m_z = `ZERO_RESET;
      `CHK({ready, done, unsup, wr_en}, 4'h0);
      `CHK({acc, opt, zero}, {m_acc, m_opt, m_z});
      rst = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic run(input logic [11:0] w);
      int i;
      logic wr;
      logic uns;
      logic [4:0] a;
      logic [7:0] d;
      i = 0;
      while (ready !== 1'b1 && i < 20) begin
         @(negedge ref_clk);
         i++;
      end
      `CHK(ready, 1'b1);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge ref_clk);
      `CHK({ready, done}, 2'b00);
      instr_valid = 1'b0;
      instr_word = ~w;
      wr = 1'b0;
      uns = 1'b0;
      a = w[4:0];
      d = m_acc;
      if (w == `IDLE_WORD) begin
      end else if (w == `OPTION_WORD) begin
         m_opt = m_acc;
      end else if (w[11:6] == `COPY_PREFIX) begin
         d = mem[a];
         m_z = (d == 8'h00);
         wr = w[5];
         if (!w[5]) m_acc = d;
      end else if (w[11:8] == `LIT_PREFIX) begin
         m_acc = w[7:0];
      end else if (w[11:5] == `STORE_PREFIX) begin
         wr = 1'b1;
      end else begin
         uns = 1'b1;
      end
      if (wr) mem[a] = d;
      @(negedge ref_clk);
      `CHK({ready, done, unsup}, {2'b11, uns});
      `CHK(acc, m_acc);
      `CHK(opt, m_opt);
      `CHK(zero, m_z);
      `CHK(wr_en, wr);
      if (wr) `CHK({wr_addr, wr_data}, {a, d});
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #200000;
      errors++;
      final_report();
   end

   initial begin
      logic [11:0] w;
      errors = 0;
      comparisons = 0;
      seed = 32'hef06aa6f;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 12'h000;
      do_reset(6);
      $display("test reset done");
      for (int a = 0; a < 32; a++) begin
         seed = lfsr(seed);
         run({`LIT_PREFIX, seed[7:0]});
         run({`STORE_PREFIX, 5'(a)});
      end
      $display("test fill done");
      // zero data, write-back, store then copy of the same place
      foreach (w_list[k]) run(w_list[k]);
      $display("test directed done");
      for (int k = 0; k < 400; k++) begin
         seed = lfsr(seed);
         case (seed[14:12])
            3'h0: w = {`COPY_PREFIX, seed[5:0]};
            3'h1: w = {`LIT_PREFIX, seed[7:0]};
            3'h2: w = {`STORE_PREFIX, seed[4:0]};
            3'h3: w = `OPTION_WORD;
            3'h4: w = `IDLE_WORD;
            default: w = seed[11:0];
         endcase
         run(w);
         if (k == 200) do_reset(2);
      end
      $display("test random done");
      final_report();
   end

endmodule
`default_nettype wire
